//--- pbsc_core.sv
// Purpose: synchronous pipelined burst SRAM core with byte-lane writes
// Assumes: controller drives all bus inputs on core_clk; output enable is async
// Notes: write data passes a buffer before reaching the array; reads forward from it
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// Write buffer
// ***************************************************************
module pbsc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	localparam int CNT_W = $clog2(DEPTH + 1),
	localparam int IDX_W = $clog2(DEPTH)
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic full,
	output logic [DEPTH-1:0][WIDTH-1:0] entries,
	output logic [CNT_W-1:0] count
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [CNT_W-1:0] cnt;
	} pbsc_fifo_s;

	pbsc_fifo_s s_reg;
	pbsc_fifo_s s_next;
	logic push;
	logic pop;

	if (DEPTH < 2 || (1 << IDX_W) != DEPTH) begin : g_depth_chk
		$error("pbsc_fifo: DEPTH must be a power of two of at least 2");
	end

	assign full = (s_reg.cnt == CNT_W'(DEPTH));
	assign out_valid = (s_reg.cnt != '0);
	// A full buffer still accepts when its head leaves in the same cycle
	assign in_ready = ~full | out_ready;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = s_reg.mem[0];
	assign entries = s_reg.mem;
	assign count = s_reg.cnt;

	// Oldest entry always sits at index 0, so readers can scan by age
	always_comb begin
		s_next = s_reg;
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				s_next.mem[i] = s_reg.mem[i+1];
			end
			s_next.cnt = s_reg.cnt - CNT_W'(1);
		end
		if (push) begin
			s_next.mem[s_next.cnt[IDX_W-1:0]] = in_data;
			s_next.cnt = s_next.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule : pbsc_fifo

// ***************************************************************
// SRAM core
// ***************************************************************
// Functional notes
// - High order input gives interleaved XOR burst
// - Low order input gives linear wrapping burst
// - Selected only with all three selects
// - Load read captures address, drives with enable
// - Advance reads next address, ignores selects
// - Read start, enable high: pins stay tristated
// - Read continue, enable high: advance, tristated
// - Load write with lane active starts write
// - Write burst writes next address, selected lanes
// - Write start without lanes changes nothing
// - Write continue without lanes only advances
// - Qualifier high ignores the edge on the bus; buffer drain and sleep sync still run
// - Write cycle tristates every data lane
// - Drive set by pipeline op and enable
// - Powers up deselected, pins tristated
// - Output enable acts on drivers asynchronously
// - Output enable masked during write cycles
// - Write strobe high means read, lanes ignored
// - Four lanes of nine bits, wide build
// - Two independent lanes, narrow build
// - Any lane mix writes exactly those lanes
// - Tristate next rise, capture data after
// - Read data out next rise; deselect pipelined
// - Advance steps counter; burst type held
// - Sleep input: two-cycle entry, tristated
module pbsc_core
	import pbsc_pkg::*;
#(
	parameter int LANES = 4,
	parameter int ADDR_W = 19,
	parameter int MEM_AW = 6,
	localparam int WORD_W = LANES * LANE_W,
	localparam int DATA_W = LANES * LANE_DATA_W
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic select_first_n,
	input wire logic select_second,
	input wire logic select_third_n,
	input wire logic advance_or_load_n,
	input wire logic write_enable_n,
	input wire logic [LANES-1:0] byte_lane_selects_n,
	input wire logic output_enable_n,
	input wire logic clock_qualify_n,
	input wire logic sleep_request,
	input wire logic burst_order_interleaved,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe_n,
	input wire logic [LANES-1:0] parity_pins_in,
	output logic [LANES-1:0] parity_pins_out,
	output logic parity_pins_oe_n,
	output logic wbuf_ready,
	output logic sleep_active
);
	localparam int ENT_W = $bits(pbsc_wentry_s);
	localparam int CNT_W = $clog2(WBUF_DEPTH + 1);

	if (LANES != 2 && LANES != 4) begin : g_lane_chk
		$error("pbsc_core: LANES must be 2 or 4");
	end
	if (ADDR_W > EXT_ADDR_W || MEM_AW > ADDR_W || MEM_AW < BURST_W) begin : g_addr_chk
		$error("pbsc_core: address widths out of range");
	end

	typedef struct packed {
		logic [(1<<MEM_AW)-1:0][WORD_W-1:0] mem;
		pbsc_stage_s stage1;
		pbsc_stage_s stage2;
		pbsc_burst_s burst;
		logic drive;
		logic [WORD_W-1:0] rdata;
		logic sleep_meta;
		logic sleep_sync;
		logic asleep;
		logic [SLEEP_CNT_W-1:0] sleep_cnt;
	} pbsc_core_s;

	pbsc_core_s s_reg;
	pbsc_core_s s_next;

	logic edge_ok;
	logic selected;
	logic rd_now;
	logic buf_in_valid;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	logic buf_full;
	logic [CNT_W-1:0] buf_count;
	logic [WBUF_DEPTH-1:0][ENT_W-1:0] buf_entries;
	logic [ENT_W-1:0] buf_head_raw;
	pbsc_wentry_s head;
	pbsc_wentry_s incoming;

	// ***************************************************************
	// Helpers
	// ***************************************************************
	// lane-exact merge
	function automatic logic [WORD_W-1:0] lane_merge(
		input logic [WORD_W-1:0] old_w,
		input logic [WORD_W-1:0] new_w,
		input logic [LANES-1:0] mask
	);
		logic [WORD_W-1:0] r;
		r = old_w;
		for (int i = 0; i < LANES; i++) begin
			if (mask[i]) begin
				r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
			end
		end
		return r;
	endfunction : lane_merge

	function automatic logic [BURST_W-1:0] burst_low(
		input logic [BURST_W-1:0] start,
		input logic [BURST_W-1:0] step,
		input logic ilv
	);
		logic [BURST_W-1:0] r;
		if (ilv) begin
			r = start ^ step;
		end else begin
			r = start + step;
		end
		return r;
	endfunction : burst_low

	function automatic logic [MEM_AW-1:0] row(input logic [EXT_ADDR_W-1:0] a);
		return a[MEM_AW-1:0];
	endfunction : row

	// ***************************************************************
	// Decode and buffer hookup
	// ***************************************************************
	// all selects active
	assign selected = ~select_first_n & select_second & ~select_third_n;
	assign edge_ok = ~clock_qualify_n & ~s_reg.asleep;
	assign rd_now = edge_ok & (s_reg.stage1.op == OP_READ);
	// Draining yields to the read port unless the buffer has no room left
	assign buf_out_ready = ~rd_now | buf_full;
	assign wbuf_ready = buf_in_ready;
	assign head = pbsc_wentry_s'(buf_head_raw);

	always_comb begin
		incoming = '0;
		incoming.addr = s_reg.stage2.addr;
		incoming.mask = s_reg.stage2.mask;
		for (int i = 0; i < LANES; i++) begin
			incoming.word[i*LANE_W +: LANE_DATA_W] = dq_in[i*LANE_DATA_W +: LANE_DATA_W];
			incoming.word[i*LANE_W + LANE_PAR_POS] = parity_pins_in[i];
		end
	end

	assign buf_in_valid = edge_ok & (s_reg.stage2.op == OP_WRITE) & (|s_reg.stage2.mask);

	pbsc_fifo #(
		.WIDTH(ENT_W),
		.DEPTH(WBUF_DEPTH)
	) u_wbuf (
		.core_clk(core_clk),
		.nrst(nrst),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(incoming),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_head_raw),
		.full(buf_full),
		.entries(buf_entries),
		.count(buf_count)
	);

	// ***************************************************************
	// Next state
	// ***************************************************************
	always_comb begin
		pbsc_wentry_s e;
		logic [WORD_W-1:0] fwd;
		pbsc_op_e kind;
		logic [BURST_W-1:0] step;
		logic [EXT_ADDR_W-1:0] a;
		e = '0;
		fwd = '0;
		kind = OP_DESEL;
		step = BURST_START;
		a = '0;
		s_next = s_reg;

		// two-stage sync, two-cycle entry and exit
		s_next.sleep_meta = sleep_request;
		s_next.sleep_sync = s_reg.sleep_meta;
		if (s_reg.sleep_sync != s_reg.asleep) begin
			if (s_reg.sleep_cnt == SLEEP_CNT_W'(SLEEP_CYCLES - 1)) begin
				s_next.asleep = s_reg.sleep_sync;
				s_next.sleep_cnt = '0;
			end else begin
				s_next.sleep_cnt = s_reg.sleep_cnt + SLEEP_CNT_W'(1);
			end
		end else begin
			s_next.sleep_cnt = '0;
		end

		// only selected lanes reach the array
		if (buf_out_valid && buf_out_ready) begin
			s_next.mem[row(head.addr)] = lane_merge(s_reg.mem[row(head.addr)],
				head.word[WORD_W-1:0], head.mask[LANES-1:0]);
		end

		// Newest data wins: array, then buffered writes by age, then this edge
		a = s_reg.stage1.addr;
		fwd = s_reg.mem[row(a)];
		for (int i = 0; i < WBUF_DEPTH; i++) begin
			e = pbsc_wentry_s'(buf_entries[i]);
			if (CNT_W'(i) < buf_count && row(e.addr) == row(a)) begin
				fwd = lane_merge(fwd, e.word[WORD_W-1:0], e.mask[LANES-1:0]);
			end
		end
		if (buf_in_valid && row(incoming.addr) == row(a)) begin
			fwd = lane_merge(fwd, incoming.word[WORD_W-1:0], incoming.mask[LANES-1:0]);
		end

		if (s_reg.asleep) begin
			// Pending accesses are dropped; wake up deselected
			s_next.stage1.op = OP_DESEL;
			s_next.stage2.op = OP_DESEL;
			s_next.burst.kind = OP_DESEL;
			s_next.drive = 1'b0;
		end else if (edge_ok) begin
			// read data leaves on next rise
			case (s_reg.stage1.op)
				OP_READ: begin
					s_next.rdata = fwd;
					s_next.drive = 1'b1;
				end
				default: begin
					s_next.drive = 1'b0;
				end
			endcase
			s_next.stage2 = s_reg.stage1;

			if (!advance_or_load_n) begin
				if (!selected) begin
					kind = OP_DESEL;
				end else if (write_enable_n) begin
					kind = OP_READ;
				end else begin
					kind = OP_WRITE;
				end
				step = BURST_START;
				s_next.burst.base = EXT_ADDR_W'(addr);
				s_next.burst.kind = kind;
			end else begin
				kind = s_reg.burst.kind;
				step = s_reg.burst.step + BURST_STEP;
			end
			s_next.burst.step = step;
			a = s_next.burst.base;
			a[BURST_W-1:0] = burst_low(s_next.burst.base[BURST_W-1:0], step,
				burst_order_interleaved);
			s_next.stage1.op = kind;
			s_next.stage1.addr = a;
			s_next.stage1.mask = '0;
			if (kind == OP_WRITE) begin
				s_next.stage1.mask[LANES-1:0] = ~byte_lane_selects_n;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ***************************************************************
	// Pins
	// ***************************************************************
	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			dq_out[i*LANE_DATA_W +: LANE_DATA_W] = s_reg.rdata[i*LANE_W +: LANE_DATA_W];
			parity_pins_out[i] = s_reg.rdata[i*LANE_W + LANE_PAR_POS];
		end
	end

	assign dq_oe_n = ~(s_reg.drive & ~output_enable_n & ~s_reg.asleep &
		(s_reg.stage2.op != OP_WRITE));
	assign parity_pins_oe_n = dq_oe_n;
	assign sleep_active = s_reg.asleep;
endmodule : pbsc_core

`default_nettype wire

//--- pbsc_core_asserts.sv
// Purpose: bus-level assertions for the burst SRAM core
// Assumes: bound into every core instance
// Notes: q marks an edge that the core acts on
`timescale 1ns/1ps
`default_nettype none
module pbsc_core_asserts
	import pbsc_pkg::*;
#(
	parameter int LANES = 4
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic select_first_n,
	input wire logic select_second,
	input wire logic select_third_n,
	input wire logic advance_or_load_n,
	input wire logic write_enable_n,
	input wire logic output_enable_n,
	input wire logic clock_qualify_n,
	input wire logic sleep_request,
	input wire logic [LANES*LANE_DATA_W-1:0] dq_out,
	input wire logic dq_oe_n,
	input wire logic parity_pins_oe_n,
	input wire logic sleep_active
);
	logic q;
	logic ld_on;
	logic ld_off;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	assign q = !clock_qualify_n && !sleep_active;
	assign ld_on = q && !advance_or_load_n && !select_first_n && select_second && !select_third_n;
	assign ld_off = q && !advance_or_load_n && !ld_on;
	a_oe_async: assert property (output_enable_n |-> dq_oe_n)
		else $error("drive on with output enable off");
	a_lanes_joint: assert property (dq_oe_n == parity_pins_oe_n)
		else $error("data and parity drive differ");
	a_write_tri: assert property (ld_on && !write_enable_n ##1 q |=> dq_oe_n)
		else $error("drive on in write data slot");
	a_read_drive: assert property (ld_on && write_enable_n ##1 q |=> output_enable_n || !dq_oe_n)
		else $error("read data not driven");
	a_desel_tri: assert property (ld_off ##1 q |=> dq_oe_n)
		else $error("drive on after deselect");
	a_desel_cont: assert property (ld_off ##1 (q && advance_or_load_n) ##1 q |=> dq_oe_n)
		else $error("drive on in continued deselect");
	a_stall_hold: assert property (clock_qualify_n && !sleep_active |=> $stable(dq_out))
		else $error("output moved on ignored edge");
	a_sleep_tri: assert property (sleep_active |-> dq_oe_n)
		else $error("drive on during sleep");
	a_sleep_entry: assert property ($rose(sleep_request) |-> ##[1:8] sleep_active)
		else $error("sleep not entered in time");
	a_reset_idle: assert property ($rose(nrst) |-> dq_oe_n)
		else $error("drive on after reset");
endmodule : pbsc_core_asserts
bind pbsc_core pbsc_core_asserts #(.LANES(LANES)) u_pbsc_core_asserts (.core_clk(core_clk),
	.nrst(nrst), .select_first_n(select_first_n), .select_second(select_second),
	.select_third_n(select_third_n), .advance_or_load_n(advance_or_load_n),
	.write_enable_n(write_enable_n), .output_enable_n(output_enable_n),
	.clock_qualify_n(clock_qualify_n), .sleep_request(sleep_request), .dq_out(dq_out),
	.dq_oe_n(dq_oe_n), .parity_pins_oe_n(parity_pins_oe_n), .sleep_active(sleep_active));
`default_nettype wire

//--- pbsc_core_tb.sv
// Purpose: self-checking bench for the burst SRAM core, 36-bit build
// Assumes: controller model owns every bus pin except reset
// Notes: reads are queued one beat late so the output enable of the data cycle is known
`timescale 1ns/1ps
`default_nettype none
module pbsc_core_tb;
	localparam logic [2:0] SEL_ON = 3'h2;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [18:0] addr;
	logic [18:0] a;
	logic [18:0] base = 19'h0;
	logic [2:0] sel;
	logic adv, we_n, oe_n, cq_n, zz, ilv, dq_oe_n, par_oe_n, wbuf_ready, sleep_active, qual;
	logic [3:0] bw_n;
	logic [3:0] par_out;
	logic [35:0] wd;
	logic [31:0] dq_out;
	logic [35:0] mem [64];
	logic [35:0] expq [$];
	logic [35:0] pr_data;
	logic pr_valid = 1'b0;
	logic wk = 1'b0;
	logic rk = 1'b0;
	logic ilv_m = 1'b0;
	logic oe_m = 1'b0;
	logic [1:0] n = 2'h0;
	logic [31:0] lfsr_state = 32'h00015498;
	logic [31:0] r;
	int num_errors = 0;
	int total_checks = 0;
	always #20 core_clk = ~core_clk;
	initial for (int i = 0; i < 64; i++) mem[i] = 36'h0;
	pbsc_ctrl_model u_pbsc_ctrl_model (.core_clk(core_clk), .addr(addr), .sel(sel), .adv(adv),
		.we_n(we_n), .bw_n(bw_n), .oe_n(oe_n), .cq_n(cq_n), .zz(zz), .ilv(ilv), .wd(wd));
	pbsc_core u_pbsc_core (.core_clk(core_clk),
		.nrst(nrst), .addr(addr), .select_first_n(sel[2]), .select_second(sel[1]),
		.select_third_n(sel[0]), .advance_or_load_n(adv), .write_enable_n(we_n),
		.byte_lane_selects_n(bw_n), .output_enable_n(oe_n), .clock_qualify_n(cq_n),
		.sleep_request(zz), .burst_order_interleaved(ilv), .dq_in(wd[31:0]), .dq_out(dq_out),
		.dq_oe_n(dq_oe_n), .parity_pins_in(wd[35:32]), .parity_pins_out(par_out),
		.parity_pins_oe_n(par_oe_n), .wbuf_ready(wbuf_ready), .sleep_active(sleep_active));
	function automatic logic [31:0] rnd();
		lfsr_state = {lfsr_state[30:0], ^(lfsr_state & 32'h80200003)};
		return lfsr_state;
	endfunction : rnd
	task automatic chk(input logic [35:0] e, input logic [35:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	// Burst address and lane masking worked out here, expected data queued per beat
	task automatic op(input logic ld, input logic [2:0] s, input logic w, input logic [18:0] ai,
		input logic [3:0] b);
		logic [35:0] d;
		logic [31:0] t;
		logic [5:0] ix;
		t = rnd();
		d = {t[3:0], rnd()};
		if (pr_valid && !oe_m) expq.push_back(pr_data);
		if (ld) {base, n, wk, rk} = {ai, 2'h0, s == SEL_ON && !w, s == SEL_ON && w};
		else n = n + 2'h1;
		ix = {base[5:2], ilv_m ? base[1:0] ^ n : base[1:0] + n};
		for (int i = 0; i < 4; i++) begin
			if (wk && !b[i]) {mem[ix][32+i], mem[ix][i*8+:8]} = {d[32+i], d[i*8+:8]};
		end
		{pr_valid, pr_data} = {rk, mem[ix]};
		u_pbsc_ctrl_model.issue(ld, s, w, ai, b, d, ilv_m, oe_m);
	endtask : op
	task automatic idle(input int c);
		repeat (c) op(1'b1, 3'h0, 1'b1, a, 4'h0);
	endtask : idle
	always @(posedge core_clk) begin
		qual = !cq_n && !sleep_active;
		#10;
		if (nrst && qual && dq_oe_n !== 1'b1) begin
			if (expq.size() == 0) chk(36'h0, 36'hx);
			else chk(expq.pop_front(), {par_out, dq_out});
		end
	end
	initial begin
		#(40 * 5000);
		num_errors++;
		summarize();
	end
	initial begin
		a = 19'h0;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		nrst = 1'b1;
		chk(36'h1, {35'h0, dq_oe_n});
		idle(2);
		for (int m = 0; m < 2; m++) begin
			ilv_m = m[0];
			r = rnd();
			a = r[18:0];
			op(1'b1, SEL_ON, 1'b0, a, 4'h0);
			for (int k = 0; k < 4; k++) begin
				r = rnd();
				op(1'b0, r[6:4], r[7], a, m == 1 ? r[3:0] : 4'h0);
			end
			op(1'b1, SEL_ON, 1'b1, a ^ 19'h3, r[11:8]);
			repeat (4) op(1'b0, 3'h0, 1'b0, a, 4'hf);
			idle(2);
			$display("burst test %0d done", m);
		end
		for (int s = 0; s < 8; s++) begin
			op(1'b1, s[2:0], 1'b1, a, 4'h0);
			op(1'b0, SEL_ON, 1'b0, a, 4'h0);
		end
		op(1'b1, SEL_ON, 1'b0, a, 4'hf);
		op(1'b0, SEL_ON, 1'b0, a, 4'hf);
		op(1'b1, SEL_ON, 1'b1, a, 4'h0);
		oe_m = 1'b1;
		op(1'b1, SEL_ON, 1'b1, a, 4'h0);
		op(1'b0, SEL_ON, 1'b1, a, 4'h0);
		oe_m = 1'b0;
		repeat (2) op(1'b0, SEL_ON, 1'b1, a, 4'h0);
		op(1'b1, SEL_ON, 1'b1, a, 4'h0);
		u_pbsc_ctrl_model.stall(3);
		repeat (3) op(1'b0, SEL_ON, 1'b1, a, 4'h0);
		$display("select, abort, dummy and stall tests done");
		for (int k = 0; k < 24; k++) begin
			r = rnd();
			op(!r[0] || k == 0, SEL_ON, r[1], {a[18:4], r[11:8]}, r[7:4]);
		end
		idle(2);
		chk(36'h1, {35'h0, wbuf_ready});
		$display("mixed traffic test done");
		u_pbsc_ctrl_model.sleep(1'b1);
		for (int i = 0; i < 10 && sleep_active !== 1'b1; i++) idle(1);
		chk(36'h1, {35'h0, sleep_active});
		u_pbsc_ctrl_model.sleep(1'b0);
		for (int i = 0; i < 10 && sleep_active !== 1'b0; i++) idle(1);
		chk(36'h0, {35'h0, sleep_active});
		idle(2);
		repeat (4) op(1'b1, SEL_ON, 1'b1, {a[18:4], 4'h0 + 4'(rnd())}, 4'h0);
		idle(3);
		chk(36'h0, 36'(expq.size()));
		$display("sleep test done");
		summarize();
	end
endmodule : pbsc_core_tb
`default_nettype wire

//--- pbsc_ctrl_model.sv
// Purpose: bus controller model that drives the burst SRAM core pins
// Assumes: every pin changes just after a falling core_clk
// Notes: data lines show the inverse of their last value on issue and stall beats not carrying write data
`timescale 1ns/1ps
`default_nettype none
module pbsc_ctrl_model (
	input wire logic core_clk,
	output logic [18:0] addr,
	output logic [2:0] sel,
	output logic adv,
	output logic we_n,
	output logic [3:0] bw_n,
	output logic oe_n,
	output logic cq_n,
	output logic zz,
	output logic ilv,
	output logic [35:0] wd
);
	logic wr_burst = 1'b0;
	logic pend = 1'b0;
	logic [35:0] pend_d = 36'h0;
	// Write data goes out two beats after its address beat, for the capture edge
	logic late = 1'b0;
	logic [35:0] late_d = 36'h0;
	initial begin
		{addr, sel, adv, we_n, bw_n, oe_n, cq_n, zz, ilv, wd} = '0;
	end
	// ********
	// Bus beats
	// ********
	task automatic issue(input logic ld, input logic [2:0] s, input logic w, input logic [18:0] a,
		input logic [3:0] b, input logic [35:0] d, input logic i, input logic o);
		@(negedge core_clk);
		wd = late ? late_d : ~wd;
		{adv, sel, we_n, addr, cq_n, ilv, oe_n} = {!ld, s, w, a, 1'b0, i, o};
		bw_n = b;
		wr_burst = ld ? (s == 3'h2 && !w) : wr_burst;
		{late, late_d} = {pend, pend_d};
		pend = wr_burst;
		pend_d = d;
	endtask : issue
	task automatic stall(input int c);
		repeat (c) begin
			@(negedge core_clk);
			cq_n = 1'b1;
			wd = ~wd;
		end
	endtask : stall
	task automatic sleep(input logic on);
		@(negedge core_clk);
		{sel, adv, pend, late, zz} = {3'h0, 1'b0, 1'b0, 1'b0, on};
	endtask : sleep
endmodule : pbsc_ctrl_model
`default_nettype wire

//--- pbsc_pkg.sv
// Purpose: shared constants and carriers for the pipelined burst SRAM core
// Assumes: one core clock, all bus inputs synchronous to it
// Notes: lane = 8 data bits plus one parity bit
package pbsc_pkg;
	// ***************************************************************
	// Widths and counts
	// ***************************************************************
	localparam int LANE_DATA_W = 8;
	localparam int LANE_W = 9;
	localparam int LANE_PAR_POS = 8;
	localparam int MAX_LANES = 4;
	localparam int EXT_ADDR_W = 20;
	localparam int BURST_W = 2;
	localparam int SLEEP_CYCLES = 2;
	localparam int SLEEP_CNT_W = 2;
	localparam int WBUF_DEPTH = 8;
	localparam int CORE_CLK_PERIOD_NS = 40;
	localparam logic [BURST_W-1:0] BURST_START = 2'h0;
	localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

	// ***************************************************************
	// Pipeline operation codes
	// ***************************************************************
	typedef enum logic [1:0] {
		OP_DESEL = 2'h0,
		OP_READ = 2'h1,
		OP_WRITE = 2'h3
	} pbsc_op_e;

	// ***************************************************************
	// Carriers
	// ***************************************************************
	typedef struct packed {
		logic [EXT_ADDR_W-1:0] addr;
		logic [MAX_LANES-1:0] mask;
		logic [MAX_LANES*LANE_W-1:0] word;
	} pbsc_wentry_s;

	typedef struct packed {
		pbsc_op_e op;
		logic [EXT_ADDR_W-1:0] addr;
		logic [MAX_LANES-1:0] mask;
	} pbsc_stage_s;

	typedef struct packed {
		pbsc_op_e kind;
		logic [EXT_ADDR_W-1:0] base;
		logic [BURST_W-1:0] step;
	} pbsc_burst_s;
endpackage : pbsc_pkg
